// file: verilog/pcb_top.sv
// Cache-line aware DMA burst sizing and PCI command selection with APB registers
//
// Implementation choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
`include "pcb_cfg.svh"
// Contract
// - Off a line boundary, step up in aligned sub-line bursts until it is reached.
// - Below a 4-dword boundary move single dwords only, no bursting.
// - From 4-dword boundary pick largest aligned burst not above line size, repeat.
// - At a line boundary stop aligning; burst line size or its multiples.
// - Memory move with unequal line offsets turns cache alignment off.
// - Write-invalidate needs the enable bit and command register bit 4.
// - Write-invalidate needs cache mode, enables, legal line, full line in FIFO, alignment.
// - Line commands need line size 2..128 power of two within burst cap.
// - At a line boundary burst the largest line multiple within the cap.
// - Recompute burst after every transfer from remaining data.
// - Latency expiry under write-invalidate ends the burst at the next line boundary.
// - Retry under write-invalidate: release, re-request, write-invalidate again.
// - Disconnect: release, re-request, write-invalidate only if resume is aligned.
// - Read-line enable without cache mode gives read-line on all non-fetch reads.
// - With cache mode, read-line only when all line conditions hold, else plain read.
// - Working line size is register floored to power of two, capped by burst.
module pcb_top #(
	parameter int CNT_W = 24	// Byte count width
) (
	input  wire logic             CLK_I,     // 20 MHz clock
	input  wire logic             RST_I,     // Asynchronous reset, active high
	input  wire logic             PSEL,      // APB select
	input  wire logic             PENABLE,   // APB access phase
	input  wire logic             PWRITE,    // APB write
	input  wire logic [7:0]       PADDR,     // APB byte address
	input  wire logic [31:0]      PWDATA,    // APB write data
	output logic      [31:0]      PRDATA,    // APB read data
	output logic                  PREADY,    // APB ready
	output logic                  PSLVERR,   // APB unmapped address
	input  wire logic [7:0]       FIFO_DW_I, // Dwords held in DMA FIFO
	input  wire logic             GNT_I,     // Bus grant
	input  wire logic             ACK_I,     // One dword moved this cycle
	input  wire logic             RETRY_I,   // Target retry, no data
	input  wire logic             DISC_I,    // Target disconnect
	input  wire logic             LAT_EXP_I, // Latency timer expired
	output logic                  REQ_O,     // Bus request
	output logic                  START_O,   // Address phase of a burst
	output logic                  XFER_O,    // Data phase active
	output pcb_pkg::pcb_cmd_t     CMD_O,     // PCI command of the burst
	output logic      [31:0]      ADDR_O,    // Burst start address
	output logic      [7:0]       LEN_O,     // Burst length in dwords
	output logic      [3:0]       BE_O       // Byte enables, active high
);
	import pcb_pkg::*;

	pcb_state_t       state_q;
	pcb_state_t       state_d;
	logic [4:0]       ctrl_q;
	logic [7:0]       cls_q;
	logic [7:0]       pcmd_q;
	logic [7:0]       dma_mode_register_q;
	logic [7:0]       ct3_q;
	logic [7:0]       ct5_q;
	logic [31:0]      addr_q;
	logic [31:0]      src_q;
	logic [CNT_W-1:0] cnt_q;
	pcb_cmd_t         cmd_q;
	logic [31:0]      baddr_q;
	logic [7:0]       len_q;
	logic [7:0]       left_q;
	logic [3:0]       be_q;
	logic             lat_q;
	logic             retry_q;
	logic             done_q;

	// Bus decode
	logic        wr;
	logic        rd_ok;
	logic [31:0] stat;
	logic [31:0] rdata_d;
	logic [31:0] rdata_q;
	assign wr = PSEL && PENABLE && PWRITE;
	assign PREADY = 1'b1;
	assign rd_ok = (PADDR == `PCB_OFF_CTRL) || (PADDR == `PCB_OFF_STAT) ||
		(PADDR == `PCB_OFF_ADDR) || (PADDR == `PCB_OFF_CNT) ||
		(PADDR == `PCB_OFF_SRC) || (PADDR == `PCB_OFF_CLS) ||
		(PADDR == `PCB_OFF_PCMD) || (PADDR == `PCB_OFF_DMA_MODE_REGISTER) ||
		(PADDR == `PCB_OFF_CT3) || (PADDR == `PCB_OFF_CT5);
	assign PSLVERR = PSEL && PENABLE && !rd_ok;
	assign stat = {24'h0, cmd_q, 2'h0, done_q, state_q != PCB_IDLE};
	assign rdata_d = (PADDR == `PCB_OFF_CTRL)  ? {27'h0, ctrl_q} :
		(PADDR == `PCB_OFF_STAT)  ? stat :
		(PADDR == `PCB_OFF_ADDR)  ? addr_q :
		(PADDR == `PCB_OFF_CNT)   ? 32'(cnt_q) :
		(PADDR == `PCB_OFF_SRC)   ? src_q :
		(PADDR == `PCB_OFF_CLS)   ? {24'h0, cls_q} :
		(PADDR == `PCB_OFF_PCMD)  ? {24'h0, pcmd_q} :
		(PADDR == `PCB_OFF_DMA_MODE_REGISTER) ? {24'h0, dma_mode_register_q} :
		(PADDR == `PCB_OFF_CT3)   ? {24'h0, ct3_q} :
		(PADDR == `PCB_OFF_CT5)   ? {24'h0, ct5_q} : 32'h0;
	assign PRDATA = rdata_q;

	// Read data captured in the setup cycle, so it leaves a flop with no wait state
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			rdata_q <= 32'h0;
		end else if (PSEL && !PENABLE) begin
			rdata_q <= rdata_d;
		end
	end

	wire idle     = (state_q == PCB_IDLE);
	wire wr_ctrl  = wr && (PADDR == `PCB_OFF_CTRL);
	wire go       = wr_ctrl && PWDATA[`PCB_CTRL_START] && idle && (cnt_q != '0);
	wire is_write = ctrl_q[`PCB_CTRL_WRITE];

	// Burst cap and working line size
	logic [2:0] bcode;
	logic [7:0] max_dw;
	logic [7:0] cls_fl;
	logic [7:0] line_dw;
	logic       cls_legal;
	assign bcode = {ct5_q[`PCB_CT5_BSZ], dma_mode_register_q[`PCB_DM_BSZ_HI:`PCB_DM_BSZ_LO]};
	assign max_dw = (bcode >= `PCB_BCODE_MAX) ? `PCB_DW_TOP : (`PCB_DW_MIN << bcode);
	always_comb begin
		cls_fl = 8'h00;
		for (int i = 1; i < 8; i++) begin
			if (cls_q[i]) begin
				cls_fl = 8'(1 << i);
			end
		end
	end
	assign line_dw = (cls_fl > max_dw) ? max_dw : cls_fl;
	assign cls_legal = (cls_q == cls_fl) && (cls_fl != 8'h00) && (cls_q <= max_dw);

	// Alignment against the working line
	logic [9:0] lmask;
	logic       mm_mis;
	logic       cme_eff;
	logic       line_al;
	assign lmask = {line_dw - 8'h01, 2'h3};
	assign mm_mis = ctrl_q[`PCB_CTRL_MOVE] &&
		((addr_q[9:0] & lmask) != (src_q[9:0] & lmask));
	assign cme_eff = ctrl_q[`PCB_CTRL_CME] && !mm_mis && (line_dw != 8'h00);
	assign line_al = ((addr_q[9:0] & lmask) == 10'h000);

	// Command choice
	logic     mwi_ok;
	logic     rl_ok;
	pcb_cmd_t cmd_next;
	assign mwi_ok = cme_eff && ct3_q[`PCB_CT3_WIE] && pcmd_q[`PCB_PCMD_MWI] &&
		cls_legal && (FIFO_DW_I >= line_dw) && line_al &&
		(cnt_q >= CNT_W'({line_dw, 2'h0}));
	assign rl_ok = cme_eff && dma_mode_register_q[`PCB_DM_RLE] && cls_legal &&
		(cnt_q >= CNT_W'({max_dw, 2'h0})) && line_al;
	assign cmd_next = is_write ? ((mwi_ok || retry_q) ? `PCB_PCI_MWI : `PCB_PCI_MW) :
		ctrl_q[`PCB_CTRL_FETCH] ? `PCB_PCI_MR :
		!cme_eff ? (dma_mode_register_q[`PCB_DM_RLE] ? `PCB_PCI_MRL : `PCB_PCI_MR) :
		(rl_ok ? `PCB_PCI_MRL : `PCB_PCI_MR);

	// Burst length
	logic [CNT_W:0]   cnt_p3;
	logic [CNT_W-1:0] rem_dw;
	logic [7:0]       calc_len;
	assign cnt_p3 = {1'b0, cnt_q} + (CNT_W+1)'(`PCB_RND);
	assign rem_dw = CNT_W'(cnt_p3 >> 2);

	pcb_burst_calc #(
		.CNT_W(CNT_W)
	) pcb_burst_calc_i (
		.addr_i    (addr_q),
		.rem_dw_i  (rem_dw),
		.line_dw_i (line_dw),
		.max_dw_i  (max_dw),
		.cache_on_i(cme_eff),
		.len_o     (calc_len)
	);

	// Bytes of the current dword and their enables
	logic [2:0]       lead;
	logic [2:0]       nb;
	logic [3:0]       be_n;
	logic [3:0]       be_nx;
	logic [CNT_W-1:0] cnt_after;
	logic [9:0]       addr_nx;
	assign lead = 3'h4 - {1'b0, addr_q[1:0]};
	assign nb = (cnt_q < CNT_W'(lead)) ? cnt_q[2:0] : lead;
	assign be_n = (4'hF << addr_q[1:0]) & ~(4'hF << ({1'b0, addr_q[1:0]} + nb));
	assign cnt_after = cnt_q - CNT_W'(nb);
	assign be_nx = (cnt_after >= CNT_W'(3'h4)) ? 4'hF : ~(4'hF << cnt_after[1:0]);
	assign addr_nx = addr_q[9:0] + 10'(nb);

	// Sequencing
	wire load     = (state_q == PCB_REQ) && GNT_I;
	wire in_data  = (state_q == PCB_DATA);
	wire mwi_run  = (cmd_q == `PCB_PCI_MWI);
	wire last     = in_data && ACK_I && !RETRY_I && (cnt_after == '0);
	wire next_al  = ((addr_nx & lmask) == 10'h000);
	wire lat_stop = (lat_q || LAT_EXP_I) && ACK_I && (!mwi_run || next_al);
	wire moved    = in_data && ACK_I && !RETRY_I;

	always_comb begin
		state_d = state_q;
		unique case (state_q)
			PCB_IDLE: begin
				if (go) begin
					state_d = PCB_REQ;
				end
			end
			PCB_REQ: begin
				if (GNT_I) begin
					state_d = PCB_ADDR;
				end
			end
			PCB_ADDR: begin
				state_d = PCB_DATA;
			end
			PCB_DATA: begin
				if (RETRY_I) begin
					state_d = PCB_REQ;
				end else if (last) begin
					state_d = PCB_IDLE;
				end else if (ACK_I && DISC_I) begin
					state_d = PCB_REQ;
				end else if (lat_stop) begin
					state_d = PCB_GAP;
				end else if (ACK_I && (left_q == 8'h01)) begin
					state_d = PCB_REQ;
				end
			end
			PCB_GAP: begin
				state_d = PCB_REQ;
			end
		endcase
	end

	assign REQ_O   = (state_q == PCB_REQ);
	assign START_O = (state_q == PCB_ADDR);
	assign XFER_O  = in_data;
	assign CMD_O   = cmd_q;
	assign ADDR_O  = baddr_q;
	assign LEN_O   = len_q;
	assign BE_O    = be_q;

	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			state_q <= PCB_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Software registers
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			ctrl_q  <= 5'h00;
			cls_q   <= 8'h00;
			pcmd_q  <= 8'h00;
			dma_mode_register_q <= 8'h00;
			ct3_q   <= 8'h00;
			ct5_q   <= 8'h00;
			src_q   <= 32'h0;
		end else if (wr && idle) begin
			if (PADDR == `PCB_OFF_CTRL)  ctrl_q  <= PWDATA[4:0];
			if (PADDR == `PCB_OFF_CLS)   cls_q   <= PWDATA[7:0];
			if (PADDR == `PCB_OFF_PCMD)  pcmd_q  <= PWDATA[7:0];
			if (PADDR == `PCB_OFF_DMA_MODE_REGISTER) dma_mode_register_q <= PWDATA[7:0];
			if (PADDR == `PCB_OFF_CT3)   ct3_q   <= PWDATA[7:0];
			if (PADDR == `PCB_OFF_CT5)   ct5_q   <= PWDATA[7:0];
			if (PADDR == `PCB_OFF_SRC)   src_q   <= PWDATA;
		end
	end

	// Working address and count advance per moved dword
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			addr_q <= 32'h0;
			cnt_q  <= '0;
		end else if (moved) begin
			addr_q <= addr_q + 32'(nb);
			cnt_q  <= cnt_after;
		end else if (wr && idle && (PADDR == `PCB_OFF_ADDR)) begin
			addr_q <= PWDATA;
		end else if (wr && idle && (PADDR == `PCB_OFF_CNT)) begin
			cnt_q <= PWDATA[CNT_W-1:0];
		end
	end

	// Burst descriptor, loaded on grant
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			cmd_q   <= `PCB_PCI_MR;
			baddr_q <= 32'h0;
			len_q   <= 8'h00;
			left_q  <= 8'h00;
			be_q    <= 4'h0;
		end else if (load) begin
			cmd_q   <= cmd_next;
			baddr_q <= addr_q;
			len_q   <= calc_len;
			left_q  <= calc_len;
			be_q    <= be_n;
		end else if (moved) begin
			left_q <= left_q - 8'h01;
			be_q   <= be_nx;
		end
	end

	// Termination and completion flags; a finishing transfer beats a clear
	always_ff @(posedge CLK_I or posedge RST_I) begin
		if (RST_I) begin
			lat_q   <= 1'b0;
			retry_q <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			lat_q   <= load ? 1'b0 : (lat_q || (in_data && LAT_EXP_I));
			retry_q <= (in_data && RETRY_I) ? mwi_run : (load ? 1'b0 : retry_q);
			done_q  <= last || (done_q && !(wr && (PADDR == `PCB_OFF_STAT) &&
				PWDATA[`PCB_ST_DONE]));
		end
	end

	// Checks
	single_dword_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O && cme_eff && (ADDR_O[3:0] != 4'h0) &&
		((ADDR_O[9:2] & (line_dw - 8'h01)) != 8'h00)
		|-> LEN_O == 8'h01)
		else $error("unaligned burst longer than one dword");
	burst_cap_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O |-> (LEN_O <= max_dw) && (LEN_O != 8'h00))
		else $error("burst length outside cap");
	mwi_enable_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O && (CMD_O == `PCB_PCI_MWI) && !$past(retry_q)
		|-> ct3_q[`PCB_CT3_WIE] && pcmd_q[`PCB_PCMD_MWI] && ctrl_q[`PCB_CTRL_CME])
		else $error("write-invalidate without enables");
	mwi_line_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O && (CMD_O == `PCB_PCI_MWI) && !$past(retry_q)
		|-> ((ADDR_O[9:0] & lmask) == 10'h000) && (LEN_O >= line_dw) &&
		((LEN_O & (line_dw - 8'h01)) == 8'h00))
		else $error("write-invalidate burst not whole lines");
	fetch_read_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O && !is_write && ctrl_q[`PCB_CTRL_FETCH] |-> CMD_O == `PCB_PCI_MR)
		else $error("fetch used a line command");
	move_off_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		load && mm_mis && !retry_q |=> CMD_O != `PCB_PCI_MWI)
		else $error("write-invalidate on misaligned move");
	retry_again_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		in_data && RETRY_I && mwi_run |=> REQ_O && retry_q)
		else $error("retry did not re-request the bus");
	retry_mwi_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		load && retry_q |=> CMD_O == `PCB_PCI_MWI)
		else $error("retry did not repeat write-invalidate");
	lead_bytes_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		START_O && (ADDR_O[1:0] != 2'h0) |->
		((BE_O & ~(4'hF << ADDR_O[1:0])) == 4'h0) && (BE_O != 4'h0))
		else $error("leading byte enables wrong");
	lat_hold_a: assert property (@(posedge CLK_I) disable iff (RST_I)
		in_data && mwi_run && ACK_I && LAT_EXP_I && !next_al && !RETRY_I && !DISC_I &&
		(left_q != 8'h01) && !last |=> XFER_O)
		else $error("latency expiry cut a line short");
endmodule : pcb_top

// file: shared/pcb_cfg.svh
// Offsets, field positions and encodings for the burst and command selector
`ifndef PCB_CFG_SVH
`define PCB_CFG_SVH
`define PCB_OFF_CTRL   8'h00
`define PCB_OFF_STAT   8'h04
`define PCB_OFF_ADDR   8'h08
`define PCB_OFF_CNT    8'h0C
`define PCB_OFF_SRC    8'h10
`define PCB_OFF_CLS    8'h14
`define PCB_OFF_PCMD   8'h18
`define PCB_OFF_DMA_MODE_REGISTER  8'h1C
`define PCB_OFF_CT3    8'h20
`define PCB_OFF_CT5    8'h24
`define PCB_CTRL_START 0
`define PCB_CTRL_WRITE 1
`define PCB_CTRL_FETCH 2
`define PCB_CTRL_MOVE  3
`define PCB_CTRL_CME   4
`define PCB_ST_DONE    1
`define PCB_PCMD_MWI   4
`define PCB_CT3_WIE    0
`define PCB_DM_RLE     3
`define PCB_DM_BSZ_HI  7
`define PCB_DM_BSZ_LO  6
`define PCB_CT5_BSZ    2
`define PCB_BCODE_MAX  3'h6
`define PCB_DW_MIN     8'h02
`define PCB_DW_TOP     8'h80
`define PCB_RND        3
`define PCB_PCI_MR     4'h6
`define PCB_PCI_MW     4'h7
`define PCB_PCI_MRL    4'hE
`define PCB_PCI_MWI    4'hF
`endif

// file: shared/pcb_pkg.sv
// Types for the burst and command selector
package pcb_pkg;
	typedef logic [3:0] pcb_cmd_t;
	typedef enum logic [2:0] {PCB_IDLE, PCB_REQ, PCB_ADDR, PCB_DATA, PCB_GAP} pcb_state_t;
endpackage : pcb_pkg

// file: verilog/pcb_burst_calc.sv
// Burst length selection: single dwords, alignment stepping, line multiples
`timescale 1ns/1ps
module pcb_burst_calc #(
	parameter int CNT_W = 24	// Width of remaining dword count
) (
	input  wire logic [31:0]      addr_i,     // Current byte address
	input  wire logic [CNT_W-1:0] rem_dw_i,   // Remaining dwords
	input  wire logic [7:0]       line_dw_i,  // Working line size in dwords
	input  wire logic [7:0]       max_dw_i,   // Programmed burst cap in dwords
	input  wire logic             cache_on_i, // Cache alignment active
	output logic      [7:0]       len_o       // Chosen burst length in dwords
);
	logic [7:0] avail;
	logic [7:0] adw;
	logic [7:0] mult;
	logic [7:0] ok;
	logic [7:0] step;
	logic       at_line;

	assign avail = (rem_dw_i >= CNT_W'(max_dw_i)) ? max_dw_i : rem_dw_i[7:0];
	assign adw = addr_i[9:2];
	assign at_line = ((adw & (line_dw_i - 8'h01)) == 8'h00);
	assign mult = avail & ~(line_dw_i - 8'h01);

	// Sizes this address is aligned to, that fit and stay below the line
	generate
		for (genvar k = 0; k < 8; k++) begin : g_fit
			localparam logic [7:0] SZ = 8'(1 << k);
			assign ok[k] = (k >= 2) && (SZ <= avail) && (SZ < line_dw_i) &&
				((adw & (SZ - 8'h01)) == 8'h00);
		end
	endgenerate

	always_comb begin
		step = 8'h01;
		for (int i = 2; i < 8; i++) begin
			if (ok[i]) begin
				step = 8'(1 << i);
			end
		end
	end

	always_comb begin
		if (addr_i[1:0] != 2'h0) begin
			len_o = 8'h01;
		end else if (!cache_on_i) begin
			len_o = avail;
		end else if (at_line && (mult != 8'h00)) begin
			len_o = mult;
		end else if (addr_i[3:0] != 4'h0) begin
			len_o = 8'h01;
		end else begin
			len_o = step;
		end
	end
endmodule : pcb_burst_calc

// file: tb/pcb_target.sv
// Behavioural PCI target: grants, acknowledges and stops bursts on command
`timescale 1ns/1ps
module pcb_target (
	input  wire logic       clk_i,   // Bus clock
	input  wire logic       rst_i,   // Reset, active high
	input  wire logic       req_i,   // Request from master
	input  wire logic       xfer_i,  // Data phase of master
	input  wire logic       slow_i,  // One wait cycle per dword
	input  wire logic [1:0] stop_i,  // 0 none, 1 retry, 2 disconnect
	input  wire logic [7:0] at_i,    // Dword index that carries the disconnect
	output logic            gnt_o,   // Grant
	output logic            ack_o,   // Dword moved
	output logic            retry_o, // Stop, no data
	output logic            disc_o   // Stop together with data
);
	logic       fired_q;
	logic       wait_q;
	logic [7:0] n_q;
	assign retry_o = xfer_i & (stop_i == 2'h1) & ~fired_q;
	assign ack_o   = xfer_i & ~retry_o & ~(slow_i & wait_q);
	assign disc_o  = ack_o & (stop_i == 2'h2) & ~fired_q & (n_q == at_i);
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			gnt_o   <= 1'b0;
			fired_q <= 1'b0;
			wait_q  <= 1'b1;
			n_q     <= 8'h00;
		end else begin
			gnt_o   <= req_i;
			fired_q <= (fired_q | retry_o | disc_o) & (stop_i != 2'h0);
			wait_q  <= xfer_i ? ~wait_q : 1'b1;
			n_q     <= xfer_i ? n_q + {7'h00, ack_o} : 8'h00;
		end
	end
endmodule : pcb_target

// file: tb/pcb_top_tb.sv
// Self-checking bench: register access, burst geometry and command choice
`timescale 1ns/1ps
`include "pcb_cfg.svh"
module pcb_top_tb;
	import pcb_pkg::*;
	logic        clk, rst, psel, penable, pwrite, lat_exp, slow, err;
	logic        gnt, ack, retry, disc, req, start, xfer, pready, pslverr;
	logic [7:0]  paddr, fifo_dw, len, stop_at;
	logic [31:0] pwdata, prdata, addr, rd;
	logic [1:0]  stop_kind;
	logic [3:0]  be;
	pcb_cmd_t    cmd, c;
	logic [47:0] seen_q[$];
	logic [47:0] exp_q[$];
	int          num_errors, check_count;
	int          cycles = 0;
	logic [31:0] rctl [5] = '{32'h0, 32'h4, 32'h0, 32'h10, 32'h10};
	pcb_cmd_t    rcmd [5] = '{4'hE, 4'h6, 4'h6, 4'hE, 4'h6};

	pcb_top pcb_top_i (.CLK_I(clk), .RST_I(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .FIFO_DW_I(fifo_dw), .GNT_I(gnt), .ACK_I(ack), .RETRY_I(retry),
		.DISC_I(disc), .LAT_EXP_I(lat_exp), .REQ_O(req), .START_O(start), .XFER_O(xfer),
		.CMD_O(cmd), .ADDR_O(addr), .LEN_O(len), .BE_O(be));
	pcb_target pcb_target_i (.clk_i(clk), .rst_i(rst), .req_i(req), .xfer_i(xfer),
		.slow_i(slow), .stop_i(stop_kind), .at_i(stop_at), .gnt_o(gnt), .ack_o(ack),
		.retry_o(retry), .disc_o(disc));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic conclude();
		if (num_errors == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	// Burst log, taken in the address-phase cycle, and hang guard
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (start === 1'b1)
			seen_q.push_back({cmd, addr, len, be});
		if (cycles == 30000) begin
			num_errors = num_errors + 1;
			conclude();
		end
	end

	task automatic check(input logic [47:0] seen, input logic [47:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			num_errors = num_errors + 1;
			$display("wrong value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		@(posedge clk);
		while (pready !== 1'b1)
			@(posedge clk);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask : apb

	task automatic cfg(input logic [7:0] cls, input logic [7:0] dm, input logic [7:0] c3,
		input logic [31:0] src);
		apb(1'b1, `PCB_OFF_CLS, {24'h0, cls});
		apb(1'b1, `PCB_OFF_PCMD, 32'h10);
		apb(1'b1, `PCB_OFF_DMA_MODE_REGISTER, {24'h0, dm});
		apb(1'b1, `PCB_OFF_CT3, {24'h0, c3});
		apb(1'b1, `PCB_OFF_CT5, 32'h4);
		apb(1'b1, `PCB_OFF_SRC, src);
	endtask : cfg

	// Start a job, wait for done, then clear done
	task automatic run(input logic [31:0] ctl, input logic [31:0] a, input logic [31:0] n);
		int i;
		seen_q = {};
		apb(1'b1, `PCB_OFF_ADDR, a);
		apb(1'b1, `PCB_OFF_CNT, n);
		apb(1'b1, `PCB_OFF_CTRL, ctl | 32'h1);
		i = 0;
		rd = 32'h0;
		while (rd[`PCB_ST_DONE] !== 1'b1 && i < 2000) begin
			apb(1'b0, `PCB_OFF_STAT, 32'h0);
			i = i + 1;
		end
		check(rd[`PCB_ST_DONE], 1'b1);
		apb(1'b1, `PCB_OFF_STAT, 32'h2);
	endtask : run

	task automatic ex(input pcb_cmd_t c, input logic [31:0] a, input logic [7:0] l,
		input logic [3:0] b);
		exp_q.push_back({c, a, l, b});
	endtask : ex

	task automatic cmp_all();
		check(seen_q.size(), exp_q.size());
		foreach (exp_q[k])
			check(seen_q[k], exp_q[k]);
		exp_q = {};
	endtask : cmp_all

	initial begin
		{psel, penable, pwrite, lat_exp, slow, paddr, pwdata, stop_at, stop_kind} = '0;
		fifo_dw = 8'h80;
		num_errors = 0;
		check_count = 0;
		rst = 1'b1;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		apb(1'b0, `PCB_OFF_CLS, 32'h0);
		check(rd, 32'h0);
		apb(1'b1, `PCB_OFF_CLS, 32'h10);
		apb(1'b0, `PCB_OFF_CLS, 32'h0);
		check(rd, 32'h10);
		apb(1'b0, 8'h40, 32'h0);
		check({err, rd}, {1'b1, 32'h0});
		// Unaligned write: full, no enable, short FIFO, illegal line size
		for (int v = 0; v < 4; v++) begin
			fifo_dw <= (v == 2) ? 8'h08 : 8'h80;
			cfg((v == 3) ? 8'h14 : 8'h10, 8'h40, (v == 1) ? 8'h00 : 8'h01, 32'h0);
			run(32'h12, 32'h01, 32'd383);
			c = (v == 0) ? 4'hF : 4'h7;
			ex(4'h7, 32'h01, 8'h01, 4'hE);
			for (int k = 1; k < 4; k++)
				ex(4'h7, 4 * k, 8'h01, 4'hF);
			ex(4'h7, 32'h10, 8'h04, 4'hF);
			ex(4'h7, 32'h20, 8'h08, 4'hF);
			ex(c, 32'h40, 8'h40, 4'hF);
			ex(c, 32'h140, 8'h10, 4'hF);
			cmp_all();
		end
		apb(1'b0, `PCB_OFF_STAT, 32'h0);
		check(rd[`PCB_ST_DONE], 1'b0);
		cfg(8'h10, 8'h40, 8'h01, 32'h02);
		run(32'h1A, 32'h01, 32'd63);
		ex(4'h7, 32'h01, 8'h01, 4'hE);
		ex(4'h7, 32'h04, 8'h0F, 4'hF);
		cmp_all();
		slow <= 1'b1;
		for (int r = 0; r < 5; r++) begin
			cfg(8'h10, (r == 2) ? 8'h40 : 8'h48, 8'h01, 32'h0);
			run(rctl[r], 32'h100, (r == 4) ? 32'd252 : 32'd256);
			check(seen_q[0][47:44], rcmd[r]);
		end
		slow <= 1'b0;
		cfg(8'h10, 8'h40, 8'h01, 32'h0);
		stop_kind <= 2'h1;
		run(32'h12, 32'h40, 32'd64);
		ex(4'hF, 32'h40, 8'h10, 4'hF);
		ex(4'hF, 32'h40, 8'h10, 4'hF);
		cmp_all();
		for (int d = 0; d < 2; d++) begin
			// Re-arm the target's one-shot stop before each disconnect run
			stop_kind <= 2'h0;
			@(posedge clk);
			stop_kind <= 2'h2;
			stop_at <= (d == 0) ? 8'h04 : 8'h0F;
			run(32'h12, 32'h40, 32'd128);
			check(seen_q[0], {4'hF, 32'h40, 8'h20, 4'hF});
			check(seen_q[1][47:12], (d == 0) ? {4'h7, 32'h54} : {4'hF, 32'h80});
		end
		stop_kind <= 2'h0;
		fork
			run(32'h12, 32'h40, 32'd256);
			begin
				wait (xfer === 1'b1);
				repeat (3) @(posedge clk);
				lat_exp <= 1'b1;
				@(posedge clk);
				lat_exp <= 1'b0;
			end
		join
		check(seen_q[1][47:12], {4'hF, 32'h80});
		conclude();
	end
endmodule : pcb_top_tb
